// >>> src/i2cra_pkg.sv
// Behaviour
// - Every start restarts the address phase
// - Master sends seven address bits, then direction
// - Direction zero writes, one reads
// - Acknowledge only a matching slave address
// - Mismatch: idle, bus released until start
// - Byte is eight bits plus acknowledge
// - No limit on byte count
// - First two write bytes form pointer
// - Later write bytes store from pointer
// - Pointer-only write loads pointer, no store
// - Read returns data from current pointer
// - Combined read: pointer write, restart, read
// - Master stops after last write acknowledge
// - Master nacks last read byte; slave idles
// - Master forms stop after final nack
// - Repeated start begins new address phase
// - Start or stop drops partial byte
// - Slave never drives clock nor conditions
// - Slave address selectable among four
// - Works at standard and fast rates; the master is fixed at 400 kHz only
package i2cra_pkg;

	// ----------------------------------------------------------------
	// Widths and fixed codes
	// ----------------------------------------------------------------
	localparam int          I2CRA_BYTE_W   = 8;
	localparam int          I2CRA_PTR_W    = 16;
	localparam logic [3:0]  I2CRA_ACK_BIT  = 4'h8;
	localparam logic [3:0]  I2CRA_LAST_BIT = 4'h7;
	localparam logic        I2CRA_DIR_WR   = 1'b0;
	localparam logic        I2CRA_DIR_RD   = 1'b1;
	// Upper five address bits; arbitrary value
	localparam logic [4:0]  I2CRA_DEV_BASE = 5'h0b;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          I2CRA_CLK_HZ   = 250_000_000;
	localparam int          I2CRA_SCL_HZ   = 400_000;
	localparam int          I2CRA_QTR_INT  =
		(I2CRA_CLK_HZ + 4 * I2CRA_SCL_HZ - 1) / (4 * I2CRA_SCL_HZ);
	localparam logic [7:0]  I2CRA_QTR_CYC  = I2CRA_QTR_INT[7:0];

	// ----------------------------------------------------------------
	// Host command kinds
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		I2CRA_CMD_WRITE,
		I2CRA_CMD_SEND,
		I2CRA_CMD_RECV,
		I2CRA_CMD_READ
	} i2cra_cmd_e;

endpackage

// >>> src/i2cra_if.sv
`timescale 1ns/1ps
interface i2cra_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-ups
	assign scl = scl_m_oe ? scl_m_o : 1'b1;
	assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

	modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
	modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// >>> src/i2cra_sync.sv
`timescale 1ns/1ps
module i2cra_sync (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [1:0] i_pin,
	output logic      [1:0] o_lvl,
	output logic      [1:0] o_prev
);
	// Stage one is read only by stage two
	logic [1:0] meta_r;
	logic [1:0] lvl_r;
	logic [1:0] prev_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_r <= 2'h3;
			lvl_r  <= 2'h3;
			prev_r <= 2'h3;
		end else begin
			meta_r <= i_pin;
			lvl_r  <= meta_r;
			prev_r <= lvl_r;
		end
	end

	assign o_lvl  = lvl_r;
	assign o_prev = prev_r;
endmodule

// >>> src/i2cra_slave.sv
`timescale 1ns/1ps
module i2cra_slave
	import i2cra_pkg::*;
(
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_n,
	i2cra_if.slave                       bus,
	input  wire logic [1:0]              i_addr_sel,
	input  wire logic [I2CRA_BYTE_W-1:0] i_reg_rdata,
	output logic      [I2CRA_PTR_W-1:0]  o_reg_addr,
	output logic      [I2CRA_BYTE_W-1:0] o_reg_wdata,
	output logic                         o_reg_we,
	output logic                         o_reg_re,
	output logic                         o_selected,
	output logic                         o_ptr_loaded,
	output logic                         o_addr_miss
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SL_IDLE,
		SL_ADDR,
		SL_ACK,
		SL_RX,
		SL_TX,
		SL_MACK
	} i2cra_sl_e;

	typedef struct packed {
		i2cra_sl_e               st;
		logic [3:0]              bitc;
		logic [I2CRA_BYTE_W-1:0] sh;
		logic [I2CRA_PTR_W-1:0]  ptr;
		logic [1:0]              nbyte;
		logic                    macked;
		logic                    sda_oe;
		logic [1:0]              sel_m;
		logic [1:0]              sel;
		logic [I2CRA_BYTE_W-1:0] wdata;
		logic                    we;
		logic                    re;
		logic                    selected;
		logic                    ptr_loaded;
		logic                    addr_miss;
	} i2cra_sl_s;

	i2cra_sl_s r;
	i2cra_sl_s n;

	logic [1:0] lvl;
	logic [1:0] prev;
	logic       scl;
	logic       sda;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	logic [6:0] my_addr;

	// ----------------------------------------------------------------
	// Bus sampling and condition detection
	// ----------------------------------------------------------------
	i2cra_sync u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_pin   ({bus.scl, bus.sda}),
		.o_lvl   (lvl),
		.o_prev  (prev)
	);

	assign scl     = lvl[1];
	assign sda     = lvl[0];
	assign rise    = lvl[1] & ~prev[1];
	assign fall    = ~lvl[1] & prev[1];
	// SDA edge while SCL stays high
	assign start   = lvl[1] & prev[1] & prev[0] & ~lvl[0];
	assign stop    = lvl[1] & prev[1] & ~prev[0] & lvl[0];
	assign my_addr = {I2CRA_DEV_BASE, r.sel};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n            = r;
		// Strap pin: two stages before the compare reads it
		n.sel_m      = i_addr_sel;
		n.sel        = r.sel_m;
		n.we         = 1'b0;
		n.re         = 1'b0;
		n.ptr_loaded = 1'b0;
		n.addr_miss  = 1'b0;
		// Increment one cycle after the store, so the store sees the old pointer
		if (r.we) begin
			n.ptr = r.ptr + 16'h0001;
		end
		case (r.st)
			SL_IDLE: begin
				n.sda_oe   = 1'b0;
				n.selected = 1'b0;
			end
			SL_ADDR: begin
				if (rise) begin
					n.sh   = {r.sh[6:0], sda};
					n.bitc = r.bitc + 4'h1;
				end else if (fall && r.bitc == I2CRA_ACK_BIT) begin
					if (r.sh[7:1] == my_addr) begin
						n.st       = SL_ACK;
						n.sda_oe   = 1'b1;
						n.selected = 1'b1;
						n.nbyte    = 2'h0;
					end else begin
						n.st        = SL_IDLE;
						n.addr_miss = 1'b1;
					end
				end
			end
			SL_ACK: begin
				if (fall) begin
					n.sda_oe = 1'b0;
					n.bitc   = 4'h0;
					// Direction bit still sits in sh[0] after the address byte
					if (r.nbyte == 2'h0 && r.sh[0] == I2CRA_DIR_RD) begin
						n.st     = SL_TX;
						n.sh     = i_reg_rdata;
						n.sda_oe = ~i_reg_rdata[7];
						n.re     = 1'b1;
					end else begin
						n.st = SL_RX;
					end
				end
			end
			SL_RX: begin
				if (rise) begin
					n.sh   = {r.sh[6:0], sda};
					n.bitc = r.bitc + 4'h1;
				end else if (fall && r.bitc == I2CRA_ACK_BIT) begin
					n.st     = SL_ACK;
					n.sda_oe = 1'b1;
					case (r.nbyte)
						2'h0: begin
							n.ptr[15:8] = r.sh;
							n.nbyte     = 2'h1;
						end
						2'h1: begin
							n.ptr[7:0]   = r.sh;
							n.nbyte      = 2'h2;
							n.ptr_loaded = 1'b1;
						end
						default: begin
							n.we    = 1'b1;
							n.wdata = r.sh;
							n.nbyte = 2'h3;
						end
					endcase
				end
			end
			SL_TX: begin
				if (fall) begin
					if (r.bitc == I2CRA_LAST_BIT) begin
						n.sda_oe = 1'b0;
						n.st     = SL_MACK;
						n.macked = 1'b0;
					end else begin
						n.sh     = {r.sh[6:0], 1'b0};
						n.sda_oe = ~r.sh[6];
						n.bitc   = r.bitc + 4'h1;
					end
				end
			end
			SL_MACK: begin
				if (rise && !r.macked) begin
					// A nacked last byte was still read out
					n.ptr = r.ptr + 16'h0001;
					if (sda) begin
						n.st = SL_IDLE;
					end else begin
						n.macked = 1'b1;
					end
				end else if (fall && r.macked) begin
					// Pointer settled long before this edge; read data is current
					n.st     = SL_TX;
					n.bitc   = 4'h0;
					n.sh     = i_reg_rdata;
					n.sda_oe = ~i_reg_rdata[7];
					n.re     = 1'b1;
				end
			end
			default: begin
				n.st = SL_IDLE;
			end
		endcase
		// Conditions win over any byte in flight
		if (start) begin
			n.st       = SL_ADDR;
			n.bitc     = 4'h0;
			n.sda_oe   = 1'b0;
			n.selected = 1'b0;
		end else if (stop) begin
			n.st       = SL_IDLE;
			n.sda_oe   = 1'b0;
			n.selected = 1'b0;
		end
		// Stray SCL high is harmless; in idle it only clears the bit count
		if (scl && r.st == SL_IDLE) begin
			n.bitc = 4'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Only SDA is ever driven; clock and conditions belong to the master
	assign bus.sda_s_o  = 1'b0;
	assign bus.sda_s_oe = r.sda_oe;
	assign o_reg_addr   = r.ptr;
	assign o_reg_wdata  = r.wdata;
	assign o_reg_we     = r.we;
	assign o_reg_re     = r.re;
	assign o_selected   = r.selected;
	assign o_ptr_loaded = r.ptr_loaded;
	assign o_addr_miss  = r.addr_miss;

endmodule

// >>> src/i2cra_master.sv
`timescale 1ns/1ps
module i2cra_master
	import i2cra_pkg::*;
(
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_n,
	i2cra_if.master                      bus,
	input  wire logic                    i_cmd_valid,
	input  wire i2cra_cmd_e              i_cmd_kind,
	input  wire logic [6:0]              i_cmd_dev,
	input  wire logic [I2CRA_PTR_W-1:0]  i_cmd_reg,
	input  wire logic [7:0]              i_cmd_len,
	input  wire logic [I2CRA_BYTE_W-1:0] i_wdata,
	output logic                         o_wdata_take,
	output logic      [I2CRA_BYTE_W-1:0] o_rdata,
	output logic                         o_rdata_valid,
	output logic                         o_busy,
	output logic                         o_done,
	output logic                         o_nack
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BYTE, MS_STOP} i2cra_ms_e;
	typedef enum logic [2:0] {BK_ADDR, BK_HI, BK_LO, BK_WR, BK_RD} i2cra_bk_e;

	typedef struct packed {
		i2cra_ms_e               st;
		i2cra_bk_e               bk;
		i2cra_cmd_e              kind;
		logic                    rd;
		logic [7:0]              div;
		logic [1:0]              q;
		logic [3:0]              bitc;
		logic [I2CRA_BYTE_W-1:0] sh;
		logic                    ack_bad;
		logic [6:0]              dev;
		logic [I2CRA_PTR_W-1:0]  reg_a;
		logic [7:0]              cnt;
		logic                    scl_oe;
		logic                    sda_oe;
		logic                    take;
		logic [I2CRA_BYTE_W-1:0] rdata;
		logic                    rvalid;
		logic                    done;
		logic                    nack;
		logic                    busy;
	} i2cra_ms_s;

	i2cra_ms_s  r;
	i2cra_ms_s  n;
	logic [1:0] lvl;
	logic       tick;

	i2cra_sync u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_pin   ({bus.scl, bus.sda}),
		.o_lvl   (lvl),
		.o_prev  ()
	);

	assign tick = (r.div == I2CRA_QTR_CYC - 8'h01);

	// ----------------------------------------------------------------
	// Next state: four quarter ticks per SCL period
	// ----------------------------------------------------------------
	always_comb begin
		n        = r;
		n.take   = 1'b0;
		n.rvalid = 1'b0;
		n.done   = 1'b0;
		n.div    = tick ? 8'h00 : r.div + 8'h01;
		if (r.st == MS_IDLE) begin
			n.div = 8'h00;
			n.q   = 2'h0;
			if (i_cmd_valid) begin
				n.st    = MS_START;
				n.kind  = i_cmd_kind;
				n.dev   = i_cmd_dev;
				n.reg_a = i_cmd_reg;
				n.cnt   = i_cmd_len;
				n.rd    = (i_cmd_kind == I2CRA_CMD_RECV);
				n.bk    = BK_ADDR;
				n.nack  = 1'b0;
			end
		end else if (tick) begin
			n.q = r.q + 2'h1;
			case (r.st)
				MS_START: begin
					case (r.q)
						2'h0: n.sda_oe = 1'b0;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b1;
						default: begin
							n.scl_oe = 1'b1;
							n.st     = MS_BYTE;
							n.bitc   = 4'h0;
							n.sh     = {r.dev, r.rd};
						end
					endcase
				end
				MS_BYTE: begin
					case (r.q)
						2'h0: begin
							if (r.bitc == I2CRA_ACK_BIT) begin
								n.sda_oe = (r.bk == BK_RD) && (r.cnt != 8'h01);
							end else begin
								n.sda_oe = (r.bk != BK_RD) && !r.sh[7];
							end
						end
						2'h1: n.scl_oe = 1'b0;
						2'h2: begin
							if (r.bitc == I2CRA_ACK_BIT) begin
								n.ack_bad = lvl[0];
							end else if (r.bk == BK_RD) begin
								n.sh = {r.sh[6:0], lvl[0]};
							end else begin
								n.sh = {r.sh[6:0], 1'b0};
							end
						end
						default: begin
							n.scl_oe = 1'b1;
							n.bitc   = r.bitc + 4'h1;
							if (r.bitc == I2CRA_ACK_BIT) begin
								n.bitc = 4'h0;
								if (r.bk != BK_RD && r.ack_bad) begin
									n.st   = MS_STOP;
									n.nack = 1'b1;
								end else begin
									case (r.bk)
										BK_ADDR: begin
											n.bk = r.rd ? BK_RD : BK_HI;
											n.sh = r.reg_a[15:8];
										end
										BK_HI: begin
											n.bk = BK_LO;
											n.sh = r.reg_a[7:0];
										end
										BK_LO: begin
											if (r.kind == I2CRA_CMD_SEND) begin
												n.st = MS_STOP;
											end else if (r.kind == I2CRA_CMD_READ) begin
												n.st = MS_START;
												n.rd = 1'b1;
												n.bk = BK_ADDR;
											end else begin
												n.bk   = BK_WR;
												n.sh   = i_wdata;
												n.take = 1'b1;
											end
										end
										BK_WR: begin
											n.cnt = r.cnt - 8'h01;
											if (r.cnt == 8'h01) begin
												n.st = MS_STOP;
											end else begin
												n.sh   = i_wdata;
												n.take = 1'b1;
											end
										end
										default: begin
											n.rdata  = r.sh;
											n.rvalid = 1'b1;
											n.cnt    = r.cnt - 8'h01;
											if (r.cnt == 8'h01) begin
												n.st = MS_STOP;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
				MS_STOP: begin
					case (r.q)
						2'h0: n.sda_oe = 1'b1;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b0;
						default: begin
							n.st   = MS_IDLE;
							n.done = 1'b1;
						end
					endcase
				end
				default: n.st = MS_IDLE;
			endcase
		end
		n.busy = (n.st != MS_IDLE);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign bus.scl_m_o   = 1'b0;
	assign bus.scl_m_oe  = r.scl_oe;
	assign bus.sda_m_o   = 1'b0;
	assign bus.sda_m_oe  = r.sda_oe;
	assign o_wdata_take  = r.take;
	assign o_rdata       = r.rdata;
	assign o_rdata_valid = r.rvalid;
	assign o_busy        = r.busy;
	assign o_done        = r.done;
	assign o_nack        = r.nack;
endmodule

// >>> verification/i2cra_chk.sv
`timescale 1ns/1ps
module i2cra_chk
	import i2cra_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_sda_s_oe,
	input  wire logic [1:0] i_addr_sel
);
	// ----------------------------------------------------------------
	// Wire-level byte tracking
	// ----------------------------------------------------------------
	logic       scl_q;
	logic       sda_q;
	logic       first_r;
	logic       sel_r;
	logic       rd_r;
	logic       nak_r;
	logic [3:0] bc_r;
	logic [6:0] sh_r;
	logic [9:0] hi_r;
	logic       rise;
	logic       cond;
	logic       ack9;
	logic       scl;
	logic       sda;
	logic       sda_s_oe;

	assign scl      = i_scl;
	assign sda      = i_sda;
	assign sda_s_oe = i_sda_s_oe;
	assign rise = scl & ~scl_q;
	assign cond = scl & scl_q & (sda ^ sda_q);
	assign ack9 = rise & (bc_r == 4'h8);

	always_ff @(posedge i_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		// Saturates so a long idle cannot wrap to a small count
		// Reset to saturated: the bus idled high before the first fall
		hi_r  <= (!i_rst_n || (scl && hi_r == 10'h3ff)) ? 10'h3ff :
			(!scl ? 10'h000 : hi_r + 10'h001);
		if (!i_rst_n || cond) begin
			bc_r    <= 4'h0;
			first_r <= 1'b1;
			sel_r   <= 1'b0;
			nak_r   <= 1'b0;
		end else if (rise) begin
			bc_r <= (bc_r == 4'h8) ? 4'h0 : bc_r + 4'h1;
			sh_r <= {sh_r[5:0], sda};
			if (first_r && bc_r == 4'h7) begin
				sel_r <= (sh_r == {I2CRA_DEV_BASE, i_addr_sel});
				rd_r  <= sda;
			end
			if (bc_r == 4'h8) begin
				first_r <= 1'b0;
				nak_r   <= nak_r | (sel_r & rd_r & sda & ~first_r);
			end
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_freed;
		(!sda_s_oe)[*8];
	endsequence

	a_quiet_unsel: assert property (!sel_r |-> !sda_s_oe)
		else $error("slave drives while unselected");
	a_ack_match: assert property (ack9 && first_r && sel_r |-> !sda)
		else $error("own address not acknowledged");
	a_miss_nack: assert property (ack9 && first_r && !sel_r |-> sda)
		else $error("foreign address acknowledged");
	a_write_ack: assert property (ack9 && !first_r && sel_r && !rd_r |-> !sda)
		else $error("write byte not acknowledged");
	a_nack_idle: assert property ($fell(scl) && nak_r |-> ##[1:5] s_freed)
		else $error("slave still drives after nack");
	a_stable_high: assert property (scl && scl_q |-> $stable(sda_s_oe))
		else $error("slave changed data while clock high");
	a_cond_release: assert property (cond |-> ##[0:5] !sda_s_oe)
		else $error("slave holds data line after condition");
	a_high_time: assert property ($fell(scl) |-> hi_r >= 10'h096)
		else $error("clock high phase too short");
endmodule

// >>> verification/i2c_register_access_slave_bench.sv
`timescale 1ns/1ps
module i2c_register_access_slave_bench;
	import i2cra_pkg::*;
	localparam logic [6:0] DEV = {I2CRA_DEV_BASE, 2'h2};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	i2cra_cmd_e  cmd_kind = I2CRA_CMD_WRITE;
	logic [6:0]  cmd_dev = 7'h00;
	logic [15:0] cmd_reg = 16'h0000;
	logic [7:0]  cmd_len = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wtake, rvalid, done, nack, we, we2, miss2, busy, re, sel, ld;
	logic [7:0]  rdata, reg_wdata, reg_wdata2;
	logic [15:0] reg_addr, reg_addr2;
	logic [1:0]  sel2 = 2'h0;
	logic [23:0] last2;
	logic [7:0]  mem [0:65535];
	logic [7:0]  wq [$];
	logic [7:0]  rq [$];
	int          errors = 0;
	int          checked = 0;
	int          we_cnt = 0;
	int          we2_cnt = 0;
	int          miss_cnt = 0;
	int          re_cnt = 0;
	int          ld_cnt = 0;
	i2cra_if     bus ();
	i2cra_if     bus2 ();

	always #2 clk = ~clk;

	i2cra_master i_i2cra_master (.i_clk(clk), .i_rst_n(rst_n), .bus(bus),
		.i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind), .i_cmd_dev(cmd_dev),
		.i_cmd_reg(cmd_reg), .i_cmd_len(cmd_len), .i_wdata(wdata), .o_wdata_take(wtake),
		.o_rdata(rdata), .o_rdata_valid(rvalid), .o_busy(busy), .o_done(done), .o_nack(nack));
	i2cra_slave i_i2cra_slave (.i_clk(clk), .i_rst_n(rst_n), .bus(bus), .i_addr_sel(2'h2),
		.i_reg_rdata(mem[reg_addr]), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
		.o_reg_we(we), .o_reg_re(re), .o_selected(sel), .o_ptr_loaded(ld), .o_addr_miss());
	// Second slave faces the bench directly, so faults of the master can be made
	i2cra_slave i_i2cra_slave_b (.i_clk(clk), .i_rst_n(rst_n), .bus(bus2), .i_addr_sel(sel2),
		.i_reg_rdata(mem[reg_addr2]), .o_reg_addr(reg_addr2), .o_reg_wdata(reg_wdata2),
		.o_reg_we(we2), .o_reg_re(), .o_selected(), .o_ptr_loaded(), .o_addr_miss(miss2));
	i2cra_chk i_i2cra_chk (.i_clk(clk), .i_rst_n(rst_n), .i_scl(bus.scl), .i_sda(bus.sda),
		.i_sda_s_oe(bus.sda_s_oe), .i_addr_sel(2'h2));

	always @(posedge clk) begin
		if (we) mem[reg_addr] <= reg_wdata;
		if (we) we_cnt <= we_cnt + 1;
		if (we2) we2_cnt <= we2_cnt + 1;
		if (we2) last2 <= {reg_addr2, reg_wdata2};
		if (miss2) miss_cnt <= miss_cnt + 1;
		if (re) re_cnt <= re_cnt + 1;
		if (ld) ld_cnt <= ld_cnt + 1;
		if (rvalid) rq.push_back(rdata);
	end
	always @(negedge clk) if (wtake && wq.size() != 0) wdata <= wq.pop_front();

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmd(input i2cra_cmd_e k, input logic [6:0] d, input logic [15:0] r,
		input logic [7:0] n);
		int t;
		@(negedge clk);
		cmd_kind = k;
		cmd_dev = d;
		cmd_reg = r;
		cmd_len = n;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		chk(24'(busy), 24'h1, "command not taken");
		for (t = 0; t < 60000 && done !== 1'b1; t++) @(negedge clk);
		if (t == 60000) begin
			errors++;
			$display("[ERR] %0t command never finished", $time);
			wrap_up();
		end
		chk({22'h0, busy, sel}, 24'h0, "still busy or selected");
	endtask

	// Quarter of a bench-made bit; short, the slave only needs its sync lag
	task automatic bq(input logic c, input logic d);
		bus2.scl_m_oe = ~c;
		bus2.sda_m_oe = ~d;
		repeat (8) @(negedge clk);
	endtask

	task automatic bb_bit(input logic b, output logic r);
		bq(1'b0, b);
		bq(1'b1, b);
		r = bus2.sda;
		bq(1'b1, b);
		bq(1'b0, b);
	endtask

	task automatic bb_byte(input logic [7:0] v, output logic a);
		for (int i = 7; i >= 0; i--) bb_bit(v[i], a);
		bb_bit(1'b1, a);
	endtask

	task automatic bb_start();
		bq(1'b0, 1'b1);
		bq(1'b1, 1'b1);
		bq(1'b1, 1'b0);
		bq(1'b0, 1'b0);
	endtask

	task automatic bb_stop();
		bq(1'b0, 1'b0);
		bq(1'b1, 1'b0);
		bq(1'b1, 1'b1);
	endtask

	task automatic hdr();
		logic a;
		bb_start();
		bb_byte({I2CRA_DEV_BASE, 2'h0, 1'b0}, a);
		bb_byte(8'h12, a);
		bb_byte(8'h34, a);
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		logic a;
		int   i;
		bus2.scl_m_o = 1'b0;
		bus2.sda_m_o = 1'b0;
		bus2.scl_m_oe = 1'b0;
		bus2.sda_m_oe = 1'b0;
		for (i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'ha5;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		wdata = 8'h3c;
		wq = '{8'hc3};
		cmd(I2CRA_CMD_WRITE, DEV, 16'h1234, 8'h02);
		chk(24'(nack), 24'h0, "write refused");
		chk(24'(mem[16'h1234]), 24'h3c, "first store");
		chk(24'(mem[16'h1235]), 24'hc3, "second store");
		$display("test write done");
		i = we_cnt;
		cmd(I2CRA_CMD_SEND, DEV, 16'h0040, 8'h00);
		chk(24'(we_cnt - i), 24'h0, "pointer-only stored");
		chk(24'(ld_cnt), 24'h2, "pointer loads");
		rq.delete();
		cmd(I2CRA_CMD_RECV, DEV, 16'h0000, 8'h01);
		chk({16'(rq.size()), rq[0]}, {16'h1, 8'h40 ^ 8'ha5}, "receive");
		chk(24'(re_cnt), 24'h1, "receive fetches");
		chk(24'(reg_addr), 24'h000041, "read advance");
		$display("test send receive done");
		rq.delete();
		cmd(I2CRA_CMD_READ, DEV, 16'hfffe, 8'h02);
		chk({8'h0, rq[0], rq[1]}, {8'h0, 8'hfe ^ 8'ha5, 8'hff ^ 8'ha5}, "read");
		chk(24'(re_cnt), 24'h3, "read fetches");
		chk(24'(ld_cnt), 24'h3, "combined pointer load");
		$display("test combined read done");
		i = we_cnt;
		cmd(I2CRA_CMD_WRITE, {I2CRA_DEV_BASE, 2'h1}, 16'h0000, 8'h01);
		chk(24'(nack), 24'h1, "foreign acked");
		chk(24'(we_cnt - i), 24'h0, "foreign stored");
		$display("test foreign address done");
		for (i = 0; i < 4; i++) begin
			sel2 = i[1:0];
			bb_start();
			bb_byte({I2CRA_DEV_BASE, i[1:0], 1'b0}, a);
			chk(24'(a), 24'h0, "own address");
			bb_start();
			bb_byte({I2CRA_DEV_BASE, ~i[1:0], 1'b0}, a);
			chk(24'(a), 24'h1, "other address");
			bb_stop();
		end
		chk(24'(miss_cnt), 24'h4, "miss count");
		$display("test address select done");
		sel2 = 2'h0;
		hdr();
		repeat (5) bb_bit(1'b0, a);
		hdr();
		bb_byte(8'h5a, a);
		repeat (3) bb_bit(1'b1, a);
		bb_stop();
		chk(24'(we2_cnt), 24'h1, "partial byte stored");
		chk(last2, {16'h1234, 8'h5a}, "whole byte");
		$display("test partial bytes done");
		wrap_up();
	end
endmodule
